// [gpiox_pkg.sv]
// Shared constants for the general-purpose port with external interrupts
package gpiox_pkg;

   // ----------------------------------------------------------------
   // Register bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PORT_VALUE = 8'h00;  // Port value latch
   localparam logic [7:0] OFS_DIRECTION  = 8'h01;  // Pin direction bits
   localparam logic [7:0] OFS_OPTION     = 8'h02;  // Pin option bits
   localparam logic [7:0] OFS_EDGE_SENSE = 8'h03;  // Edge sense control

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PORT_VALUE = 8'h00;
   localparam logic [7:0] RST_DIRECTION  = 8'h00;
   localparam logic [7:0] RST_OPTION     = 8'h00;
   localparam logic [7:0] RST_EDGE_SENSE = 8'h00;
   localparam logic [7:0] RST_READ_DATA  = 8'h00;

   // ----------------------------------------------------------------
   // Field encodings
   // ----------------------------------------------------------------
   localparam logic SENSE_FALLING  = 1'b0;     // Edge sense field value
   localparam logic SENSE_RISING   = 1'b1;
   localparam logic DIR_INPUT      = 1'b0;     // Pin direction bit value
   localparam logic DIR_OUTPUT     = 1'b1;
   localparam logic DET_IDLE_LEVEL = 1'b1;     // Detector level of a disabled pin
   localparam logic SYNC_RST_LEVEL = 1'b1;     // Synchroniser reset level

endpackage

// [gpiox_sync.sv]
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/100ps

module gpiox_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } gpiox_sync_state_type;

   gpiox_sync_state_type state_q;
   gpiox_sync_state_type state_d;

   // Next state: stage one feeds only stage two
   always_comb begin
      state_d = state_q;
      state_d.stage1 = async_in;
      state_d.stage2 = state_q.stage1;
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= '{stage1: {WIDTH{gpiox_pkg::SYNC_RST_LEVEL}},
                      stage2: {WIDTH{gpiox_pkg::SYNC_RST_LEVEL}}};
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.stage2;

endmodule

// [gpiox_vec_irq.sv]
// Edge detector and pending latch for one external interrupt vector
`timescale 1ns/100ps

module gpiox_vec_irq #(
   parameter int unsigned PINS = 4
) (
   // Clock and reset
   input  wire logic            sys_clk,
   input  wire logic            reset_n,
   // Pin group of this vector
   input  wire logic [PINS-1:0] pin_level,
   input  wire logic [PINS-1:0] pin_irq_en,
   // Control
   input  wire logic            sense_rising,
   input  wire logic            sense_change,
   input  wire logic            vec_fetch,
   // Request
   output logic                 pending
);

   typedef struct packed {
      logic prev_level;
      logic pending;
   } gpiox_vec_state_type;

   gpiox_vec_state_type state_q;
   gpiox_vec_state_type state_d;
   logic                combined;
   logic                edge_hit;

   // Combine the group into one detector input
   always_comb begin
      combined = gpiox_pkg::DET_IDLE_LEVEL;
      for (int i = 0; i < PINS; i++) begin
         combined = combined & (pin_irq_en[i] ? pin_level[i] : gpiox_pkg::DET_IDLE_LEVEL);
      end
   end

   // Edge selection
   // per vector edge choice
   assign edge_hit = (sense_rising == gpiox_pkg::SENSE_RISING) ?
                     (~state_q.prev_level & combined) : (state_q.prev_level & ~combined);

   // Next state: set wins over any clear in the same cycle
   always_comb begin
      state_d            = state_q;
      state_d.prev_level = combined;
      if (edge_hit) begin
         state_d.pending = 1'b1;
      end else if (vec_fetch || sense_change) begin
         state_d.pending = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= '{prev_level: gpiox_pkg::DET_IDLE_LEVEL, pending: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign pending = state_q.pending;

endmodule

// [gpiox_port.sv]
// General-purpose port slice with pin control, alternate functions and external interrupts
`timescale 1ns/100ps

module gpiox_port #(
   parameter int unsigned NUM_PINS     = 8,
   parameter int unsigned PINS_PER_VEC = 4
) (
   // Clock and reset
   input  wire logic                                 sys_clk,
   input  wire logic                                 reset_n,

   // Register port
   input  wire logic [gpiox_pkg::ADDR_W-1:0]         reg_addr,
   input  wire logic [gpiox_pkg::DATA_W-1:0]         reg_wdata,
   input  wire logic                                 reg_wr,
   input  wire logic                                 reg_rd,
   output logic      [gpiox_pkg::DATA_W-1:0]         reg_rdata,

   // Package pins
   input  wire logic [NUM_PINS-1:0]                  pin_in,
   output logic      [NUM_PINS-1:0]                  pin_out,
   output logic      [NUM_PINS-1:0]                  pin_oe_n,
   output logic      [NUM_PINS-1:0]                  pin_pullup_en,
   output logic      [NUM_PINS-1:0]                  pin_high_drv_en,

   // On-chip peripheral signals
   input  wire logic [NUM_PINS-1:0]                  alt_out_en,
   input  wire logic [NUM_PINS-1:0]                  alt_out,
   output logic      [NUM_PINS-1:0]                  alt_in,

   // Interrupt controller and CPU
   input  wire logic                                 cpu_irq_mask,
   input  wire logic [NUM_PINS/PINS_PER_VEC-1:0]     vec_fetch,
   output logic      [NUM_PINS/PINS_PER_VEC-1:0]     ext_irq_req,
   output logic                                      wake_req
);

   // ----------------------------------------------------------------
   // Types and declarations
   // ----------------------------------------------------------------
   localparam int unsigned NUM_VEC = NUM_PINS / PINS_PER_VEC;

   // Port state outside the synchroniser and vector detectors, registered as one word
   typedef struct packed {
      // Software-visible configuration
      logic [NUM_PINS-1:0]          port_value_latch;
      logic [NUM_PINS-1:0]          pin_direction_bit;
      logic [NUM_PINS-1:0]          pin_option_bit;
      logic [NUM_VEC-1:0]           ext_edge_sense_control;
      // Registered pin controls
      logic [NUM_PINS-1:0]          pin_out;
      logic [NUM_PINS-1:0]          pin_oe_n;
      logic [NUM_PINS-1:0]          pullup_en;
      logic [NUM_PINS-1:0]          high_drv_en;
      // Peripheral input, requests and read answer
      logic [NUM_PINS-1:0]          alt_in;
      logic [NUM_VEC-1:0]           irq_req;
      logic                         wake;
      logic [gpiox_pkg::DATA_W-1:0] rdata;
   } gpiox_port_state_type;

   gpiox_port_state_type state_q;
   gpiox_port_state_type state_d;

   // Decoded pin and vector signals
   logic [NUM_PINS-1:0]          pin_sync;
   logic [NUM_PINS-1:0]          pin_irq_en;
   logic [NUM_VEC-1:0]           sense_change;
   logic [NUM_VEC-1:0]           vec_pending;

   // Driver and read-back helpers
   logic [NUM_PINS-1:0]          drive_out;
   logic [NUM_PINS-1:0]          drive_val;
   logic [NUM_PINS-1:0]          push_pull;
   logic [NUM_PINS-1:0]          read_value;
   logic [gpiox_pkg::DATA_W-1:0] read_word;

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------

   // Pins are asynchronous; bring them into the clock domain first
   gpiox_sync #(
      .WIDTH    (NUM_PINS)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ----------------------------------------------------------------
   // Pin configuration decode
   // ----------------------------------------------------------------

   // Interrupt input: input direction with option bit set
   // A pin with its direction bit set never requests, whatever its option bit
   // interrupt enable decode
   assign pin_irq_en = ~state_q.pin_direction_bit & state_q.pin_option_bit;

   // Output when direction says so or a peripheral claims the pin
   // peripheral output override
   assign drive_out = state_q.pin_direction_bit | alt_out_en;

   // Driven value: peripheral output has priority over the latch
   // latch drives the pin
   assign drive_val = (alt_out_en & alt_out) | (~alt_out_en & state_q.port_value_latch);

   // Drive type from option bit
   // The same bit selects the pull-up of an input pin
   // option selects drive type
   assign push_pull = state_q.pin_option_bit;

   // ----------------------------------------------------------------
   // Edge sense changes
   // ----------------------------------------------------------------

   // A write that alters a vector's sense bit pulses its clear
   // Rewriting an unchanged bit leaves its request pending
   // detect sense change
   assign sense_change = (reg_wr && reg_addr == gpiox_pkg::OFS_EDGE_SENSE) ?
                         (reg_wdata[NUM_VEC-1:0] ^ state_q.ext_edge_sense_control) :
                         {NUM_VEC{1'b0}};

   // ----------------------------------------------------------------
   // External interrupt vectors
   // ----------------------------------------------------------------

   // One detector and pending latch per group of pins
   // Vector v owns the PINS_PER_VEC pins starting at v*PINS_PER_VEC
   generate
      for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
         gpiox_vec_irq #(
            .PINS         (PINS_PER_VEC)
         ) u_vec (
            .sys_clk      (sys_clk),
            .reset_n      (reset_n),
            .pin_level    (pin_sync[v*PINS_PER_VEC +: PINS_PER_VEC]),
            .pin_irq_en   (pin_irq_en[v*PINS_PER_VEC +: PINS_PER_VEC]),
            .sense_rising (state_q.ext_edge_sense_control[v]),
            .sense_change (sense_change[v]),
            .vec_fetch    (vec_fetch[v]),
            .pending      (vec_pending[v])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read-back value
   // ----------------------------------------------------------------

   // Data register read: latch, peripheral output or pin level
   always_comb begin
      read_value = {NUM_PINS{1'b0}};
      for (int i = 0; i < NUM_PINS; i++) begin
         if (alt_out_en[i]) begin
            read_value[i] = alt_out[i];
         end else if (state_q.pin_direction_bit[i] == gpiox_pkg::DIR_OUTPUT) begin
            read_value[i] = state_q.port_value_latch[i];
         end else begin
            read_value[i] = pin_sync[i];
         end
      end
   end

   // Register mux; unmapped offsets read as zero
   // Only the low NUM_VEC bits of the sense word exist
   always_comb begin
      read_word = {gpiox_pkg::DATA_W{1'b0}};
      unique case (reg_addr)
         gpiox_pkg::OFS_PORT_VALUE: read_word[NUM_PINS-1:0] = read_value;
         gpiox_pkg::OFS_DIRECTION:  read_word[NUM_PINS-1:0] = state_q.pin_direction_bit;
         gpiox_pkg::OFS_OPTION:     read_word[NUM_PINS-1:0] = state_q.pin_option_bit;
         gpiox_pkg::OFS_EDGE_SENSE: read_word[NUM_VEC-1:0]  = state_q.ext_edge_sense_control;
         default:                   read_word = {gpiox_pkg::DATA_W{1'b0}};
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Register writes, pin driver, peripheral input and request outputs
   always_comb begin
      state_d = state_q;

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            gpiox_pkg::OFS_PORT_VALUE: begin
               state_d.port_value_latch = reg_wdata[NUM_PINS-1:0];
            end

            gpiox_pkg::OFS_DIRECTION: begin
               state_d.pin_direction_bit = reg_wdata[NUM_PINS-1:0];
            end

            gpiox_pkg::OFS_OPTION: begin
               state_d.pin_option_bit = reg_wdata[NUM_PINS-1:0];
            end

            gpiox_pkg::OFS_EDGE_SENSE: begin
               state_d.ext_edge_sense_control = reg_wdata[NUM_VEC-1:0];
            end

            // Unmapped offsets are ignored
            default: begin
               state_d.pin_option_bit = state_q.pin_option_bit;
            end
         endcase
      end

      // Read data stand only in the cycle after the strobe
      // and are zero otherwise, so no stale answer lingers
      state_d.rdata = reg_rd ? read_word : gpiox_pkg::RST_READ_DATA;

      // Pin driver, one pin per pass
      for (int i = 0; i < NUM_PINS; i++) begin
         // Value shown whenever the pin is driven
         state_d.pin_out[i] = drive_val[i];

         // An open-drain one releases the pin
         // low always, high only push-pull
         state_d.pin_oe_n[i] = ~(drive_out[i] & (~drive_val[i] | push_pull[i]));

         // Pull-up only for inputs, high driver only when driven
         // pull-up and high driver gating
         state_d.pullup_en[i]   = ~drive_out[i] & state_q.pin_option_bit[i];
         state_d.high_drv_en[i] = drive_out[i] & push_pull[i];

         // output pin feeds latch to peripheral
         state_d.alt_in[i] = (state_q.pin_direction_bit[i] == gpiox_pkg::DIR_OUTPUT) ?
                             state_q.port_value_latch[i] : pin_sync[i];
      end

      // Requests to the CPU only when its mask is cleared
      // A masked request stays pending and shows once unmasked
      // gate with CPU mask
      state_d.irq_req = cpu_irq_mask ? {NUM_VEC{1'b0}} : vec_pending;
      // unmasked pending request wakes from Wait or Halt
      state_d.wake = |vec_pending & ~cpu_irq_mask;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Synchronous reset to the reset values; pins released
   // No pin is driven and no request is raised in reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q.port_value_latch       <= gpiox_pkg::RST_PORT_VALUE[NUM_PINS-1:0];
         state_q.pin_direction_bit      <= gpiox_pkg::RST_DIRECTION[NUM_PINS-1:0];
         state_q.pin_option_bit         <= gpiox_pkg::RST_OPTION[NUM_PINS-1:0];
         state_q.ext_edge_sense_control <= gpiox_pkg::RST_EDGE_SENSE[NUM_VEC-1:0];

         state_q.pin_out                <= {NUM_PINS{1'b0}};
         state_q.pin_oe_n               <= {NUM_PINS{1'b1}};
         state_q.pullup_en              <= {NUM_PINS{1'b0}};
         state_q.high_drv_en            <= {NUM_PINS{1'b0}};

         state_q.alt_in                 <= {NUM_PINS{1'b0}};
         state_q.irq_req                <= {NUM_VEC{1'b0}};
         state_q.wake                   <= 1'b0;
         state_q.rdata                  <= gpiox_pkg::RST_READ_DATA;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // All outputs come straight from the state register,
   // so no input reaches an output in the same cycle
   assign reg_rdata       = state_q.rdata;

   assign pin_out         = state_q.pin_out;
   assign pin_oe_n        = state_q.pin_oe_n;
   assign pin_pullup_en   = state_q.pullup_en;
   assign pin_high_drv_en = state_q.high_drv_en;
   assign alt_in          = state_q.alt_in;
   assign ext_irq_req     = state_q.irq_req;
   assign wake_req        = state_q.wake;

endmodule

// [gpiox_checker.sv]
// Port-level checker for the general-purpose port with external interrupts
`timescale 1ns/100ps

module gpiox_checker #(
   parameter int unsigned NUM_PINS     = 8,
   parameter int unsigned PINS_PER_VEC = 4
) (
   // Clock and reset
   input  wire logic                             sys_clk,
   input  wire logic                             reset_n,
   // Register port
   input  wire logic [gpiox_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [gpiox_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   input  wire logic [gpiox_pkg::DATA_W-1:0]     reg_rdata,
   // Pins and peripherals
   input  wire logic [NUM_PINS-1:0]              pin_in,
   input  wire logic [NUM_PINS-1:0]              pin_out,
   input  wire logic [NUM_PINS-1:0]              pin_oe_n,
   input  wire logic [NUM_PINS-1:0]              pin_pullup_en,
   input  wire logic [NUM_PINS-1:0]              pin_high_drv_en,
   input  wire logic [NUM_PINS-1:0]              alt_out_en,
   input  wire logic [NUM_PINS-1:0]              alt_out,
   input  wire logic [NUM_PINS-1:0]              alt_in,
   // Interrupts
   input  wire logic                             cpu_irq_mask,
   input  wire logic [NUM_PINS/PINS_PER_VEC-1:0] vec_fetch,
   input  wire logic [NUM_PINS/PINS_PER_VEC-1:0] ext_irq_req,
   input  wire logic                             wake_req
);
   logic [1:0] sense_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // Shadow of the edge sense bits written by software
   always_ff @(posedge sys_clk) begin
      if (!reset_n) sense_q <= 2'h0;
      else if (reg_wr && reg_addr == gpiox_pkg::OFS_EDGE_SENSE) sense_q <= reg_wdata[1:0];
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_dir_back: assert property ((reg_wr && reg_addr == gpiox_pkg::OFS_DIRECTION) ##1
      (reg_rd && reg_addr == gpiox_pkg::OFS_DIRECTION) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("direction readback differs from written value");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_sense_upper: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[7:2] == 6'h00)
      else $error("edge sense upper bits not zero");
   a_mask_hides: assert property (cpu_irq_mask |=> ext_irq_req == '0)
      else $error("request shown while masked");
   a_wake_follows: assert property (wake_req == (|ext_irq_req))
      else $error("wake request differs from requests");
   a_high_drv: assert property ((pin_high_drv_en & pin_oe_n) == '0)
      else $error("high driver on while pin not driven");
   a_pull_drv: assert property ((pin_pullup_en & pin_high_drv_en) == '0)
      else $error("pull-up and high driver both on");
   a_fetch_clear: assert property (vec_fetch[0] |-> ##2 !ext_irq_req[0])
      else $error("fetch did not clear request");
   a_sense_clear: assert property (reg_wr && reg_addr == 8'h03 &&
      reg_wdata[0] != sense_q[0] |-> ##2 !ext_irq_req[0])
      else $error("sense change did not clear request");
   a_req_unmasked: assert property ($rose(ext_irq_req[0]) |-> !$past(cpu_irq_mask))
      else $error("request rose after masked cycle");

   // Main scenarios
   c_req: cover property ($rose(ext_irq_req[0]));
   c_req_hi: cover property ($rose(ext_irq_req[1]));
   c_push: cover property (pin_high_drv_en != '0);
endmodule

bind gpiox_port gpiox_checker #(.NUM_PINS(NUM_PINS), .PINS_PER_VEC(PINS_PER_VEC)) gpiox_checker_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
   .pin_high_drv_en(pin_high_drv_en), .alt_out_en(alt_out_en), .alt_out(alt_out),
   .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask), .vec_fetch(vec_fetch),
   .ext_irq_req(ext_irq_req), .wake_req(wake_req));

// [gpiox_pins.sv]
// Pin-side partner: external drivers, pull-ups and floating pins
`timescale 1ns/100ps

module gpiox_pins (
   // Clock
   input  wire logic       sys_clk,
   // Port drive
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pin_pullup_en,
   // External source
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // Resolved level
   output logic      [7:0] pin_in
);
   logic [7:0] float_q = 8'h55;

   // Undriven pins show a pattern that changes every cycle
   always @(posedge sys_clk) float_q <= ~float_q;

   // Port drive wins, then outside source, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_q[i];
      end
   end
endmodule

// [gpiox_port_tb.sv]
// Self-checking testbench for the general-purpose port
`timescale 1ns/100ps

module gpiox_port_tb;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, cpu_irq_mask = 1'b0, wake_req;
   logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_high_drv_en, alt_in;
   logic [7:0] alt_out_en = 8'h00, alt_out = 8'h00, ext_en = 8'hff, ext_val = 8'hff;
   logic [1:0] vec_fetch = 2'h0, ext_irq_req;
   int         n_fail = 0, n_tests = 0, cyc = 0;

   // Clock at 40 MHz
   always #12.5 sys_clk = ~sys_clk;

   gpiox_port #(.NUM_PINS(8), .PINS_PER_VEC(4)) gpiox_port_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
      .pin_high_drv_en(pin_high_drv_en), .alt_out_en(alt_out_en), .alt_out(alt_out),
      .alt_in(alt_in), .cpu_irq_mask(cpu_irq_mask), .vec_fetch(vec_fetch),
      .ext_irq_req(ext_irq_req), .wake_req(wake_req));

   gpiox_pins gpiox_pins_inst (
      .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic complete_run();
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Idle cycles: strobes and fetch low, then let updates settle
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk) begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         vec_fetch <= 2'h0;
      end
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
   endtask

   // Read strobe for one cycle, data taken in the following cycle
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask

   // Cycle ceiling
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         complete_run();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      // Offset zero reads the pins, which idle high
      for (int a = 0; a < 5; a++)
         rdc("reset_reg", (a == 4) ? 8'h10 : 8'(a), (a == 0) ? 8'hff : 8'h00);
      chk("reset_oe_n", 8'hff, pin_oe_n);
      // Input mode reads the pin and ignores latch writes
      @(posedge sys_clk) ext_val <= 8'h3c;
      wt(4);
      rdc("in_value", gpiox_pkg::OFS_PORT_VALUE, 8'h3c);
      wr(gpiox_pkg::OFS_PORT_VALUE, 8'h00);
      wt(3);
      chk("in_oe_n", 8'hff, pin_oe_n);
      chk("in_pull", 8'h00, pin_pullup_en);
      rdc("in_value2", gpiox_pkg::OFS_PORT_VALUE, 8'h3c);
      @(posedge sys_clk) ext_val <= 8'hff;
      // Open-drain then push-pull output, readback of latch
      wr(gpiox_pkg::OFS_DIRECTION, 8'hff);
      rdc("dir_back", gpiox_pkg::OFS_DIRECTION, 8'hff);
      wr(gpiox_pkg::OFS_PORT_VALUE, 8'ha5);
      rdc("out_value", gpiox_pkg::OFS_PORT_VALUE, 8'ha5);
      wt(2);
      chk("od_oe_n", 8'ha5, pin_oe_n);
      chk("od_out", 8'h00, pin_out & ~pin_oe_n);
      chk("od_high", 8'h00, pin_high_drv_en);
      wr(gpiox_pkg::OFS_OPTION, 8'hff);
      wt(3);
      chk("pp_oe_n", 8'h00, pin_oe_n);
      chk("pp_out", 8'ha5, pin_out);
      chk("pp_high", 8'hff, pin_high_drv_en);
      chk("alt_in_out", 8'ha5, alt_in);
      // Peripheral output overrides, floating input without interrupt
      wr(gpiox_pkg::OFS_OPTION, 8'h00);
      wt(1);
      alt_out_en <= 8'h01;
      wt(3);
      chk("alt_pin", 8'h00, {7'h00, pin_out[0] | pin_oe_n[0]});
      rdc("alt_rd_out", gpiox_pkg::OFS_PORT_VALUE, 8'ha4);
      wr(gpiox_pkg::OFS_DIRECTION, 8'h00);
      wt(4);
      rdc("alt_rd_in", gpiox_pkg::OFS_PORT_VALUE, 8'hfe);
      @(posedge sys_clk) alt_out_en <= 8'h00;
      wt(3);
      // Falling edge on vector 0 pin 0
      wr(gpiox_pkg::OFS_OPTION, 8'h01);
      wt(6);
      chk("irq_none", 8'h00, {6'h00, ext_irq_req});
      chk("in_pullup", 8'h01, pin_pullup_en);
      @(posedge sys_clk) ext_val <= 8'hfe;
      wt(6);
      chk("irq_fall", 8'h01, {6'h00, ext_irq_req});
      chk("wake", 8'h01, {7'h00, wake_req});
      @(posedge sys_clk) vec_fetch <= 2'h1;
      wt(3);
      chk("irq_fetch", 8'h00, {6'h00, ext_irq_req});
      // Masked request appears once unmasked
      @(posedge sys_clk) ext_val <= 8'hff;
      wt(6);
      cpu_irq_mask <= 1'b1;
      ext_val <= 8'hfe;
      wt(6);
      chk("irq_masked", 8'h00, {6'h00, ext_irq_req});
      cpu_irq_mask <= 1'b0;
      wt(2);
      chk("irq_unmask", 8'h01, {6'h00, ext_irq_req});
      wr(gpiox_pkg::OFS_EDGE_SENSE, 8'h01);
      wt(3);
      chk("irq_sense_clr", 8'h00, {6'h00, ext_irq_req});
      rdc("sense_back", gpiox_pkg::OFS_EDGE_SENSE, 8'h01);
      @(posedge sys_clk) ext_val <= 8'hff;
      wt(6);
      chk("irq_rise", 8'h01, {6'h00, ext_irq_req});
      wr(gpiox_pkg::OFS_EDGE_SENSE, 8'h00);
      // Pins of one vector combine: pin 1 low masks pin 0
      wr(gpiox_pkg::OFS_OPTION, 8'h03);
      wt(3);
      ext_val <= 8'hfd;
      wt(6);
      vec_fetch <= 2'h1;
      wt(3);
      ext_val <= 8'hfc;
      wt(6);
      chk("irq_combine", 8'h00, {6'h00, ext_irq_req});
      // Setting the option bit on a low pin fires
      wr(gpiox_pkg::OFS_OPTION, 8'h00);
      wt(3);
      wr(gpiox_pkg::OFS_OPTION, 8'h01);
      wt(6);
      chk("irq_spurious", 8'h01, {6'h00, ext_irq_req});
      vec_fetch <= 2'h1;
      wt(3);
      // Safe enable on vector 1, rising edge
      cpu_irq_mask <= 1'b1;
      wr(gpiox_pkg::OFS_EDGE_SENSE, 8'h02);
      wr(gpiox_pkg::OFS_OPTION, 8'h10);
      wt(3);
      cpu_irq_mask <= 1'b0;
      ext_val <= 8'hec;
      wt(6);
      chk("irq1_fall", 8'h00, {6'h00, ext_irq_req});
      ext_val <= 8'hfc;
      wt(6);
      chk("irq1_rise", 8'h02, {6'h00, ext_irq_req});
      // Safe disable on vector 1
      cpu_irq_mask <= 1'b1;
      wr(gpiox_pkg::OFS_EDGE_SENSE, 8'h00);
      wr(gpiox_pkg::OFS_OPTION, 8'h00);
      wr(gpiox_pkg::OFS_EDGE_SENSE, 8'h02);
      wt(3);
      cpu_irq_mask <= 1'b0;
      ext_val <= 8'hec;
      wt(6);
      chk("irq1_off", 8'h00, {6'h00, ext_irq_req});
      complete_run();
   end
endmodule
